// ---- src/cfg_init_pkg.sv ----
// Constants for the configuration word decoder and reset initialiser
package cfg_init_pkg;
    // Configuration word location and protected region
    localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
    localparam logic [13:0] TEST_REGION_LO = 14'h2000;
    localparam logic [13:0] TEST_REGION_HI = 14'h3FFF;
    localparam logic [13:0] CFG_ERASED = 14'h3FFF;
    // Configuration field positions
    localparam int OSC_LSB = 0;
    localparam int WDT_EN_POS = 2;
    localparam int PWRUP_POS = 3;
    localparam int CP_POS = 4;
    localparam int CFG_USED_BITS = 5;
    // Oscillator selection encodings
    typedef enum logic [1:0]
    {
        LOW_POWER_CRYSTAL_MODE = 2'b00,
        STANDARD_CRYSTAL_MODE = 2'b01,
        HIGH_SPEED_CRYSTAL_MODE = 2'b10,
        RC_MODE = 2'b11
    } osc_mode_t;
    // Reset cause encoding
    typedef enum logic [2:0]
    {
        CAUSE_NONE = 3'b000,
        CAUSE_POWER_ON = 3'b001,
        CAUSE_BROWNOUT = 3'b010,
        CAUSE_MASTER_CLEAR = 3'b011,
        CAUSE_WATCHDOG = 3'b100,
        CAUSE_WAKEUP = 3'b101
    } reset_cause_t;
    // Register values after reset
    localparam logic [7:0] TIMER2_CTRL_RESET = 8'h00;
    localparam logic [7:0] TIMER2_CTRL_MASK = 8'h7F;
    localparam logic [4:0] PC_HIGH_RESET = 5'h00;
    localparam logic [7:0] STATUS_POR_RESET = 8'h18;
    localparam logic [7:0] STATUS_KEEP_LOW_MASK = 8'h07;
    localparam logic [7:0] IRQ_CTRL_KEEP_MASK = 8'h01;
    localparam int IRQ_GIE_POS = 7;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
endpackage

// ---- src/cfg_word_decode.sv ----
// Decoder for the stored configuration word
`timescale 1ns/1ps
module cfg_word_decode
(
    input wire logic [13:0] i_cfg_word,
    output logic [1:0] o_osc_select_field,
    output logic o_watchdog_enable_cfg,
    output logic o_powerup_delay_enable,
    output logic o_code_protect_bit,
    output logic [13:0] o_cfg_readback
);
    // Field extraction, programmed bit reads 0
    // RULE_04: oscillator field decode
    assign o_osc_select_field = i_cfg_word[cfg_init_pkg::OSC_LSB +: 2];
    // RULE_05: watchdog enable bit
    assign o_watchdog_enable_cfg = i_cfg_word[cfg_init_pkg::WDT_EN_POS];
    assign o_powerup_delay_enable = i_cfg_word[cfg_init_pkg::PWRUP_POS];
    assign o_code_protect_bit = i_cfg_word[cfg_init_pkg::CP_POS];
    // RULE_13: unused upper bits read one
    assign o_cfg_readback = {9'h1FF, i_cfg_word[cfg_init_pkg::CFG_USED_BITS-1:0]};
endmodule

// ---- src/config_word_and_reset_init.sv ----
// Configuration word store, decode and reset initialisation of core registers
// Behaviour
// RULE_01: programmed bits read 0, erased read 1
// RULE_02: configuration word sits at 2007h
// RULE_03: region 2000h-3FFFh only in programming mode
// RULE_04: oscillator field selects RC/HS/XT/LP
// RULE_05: watchdog enable bit 1 on, 0 off
// RULE_06: enabled watchdog unstoppable, own RC clock
// RULE_07: wake-up sets source interrupt flags
// RULE_08: wake with global enable vectors to 0004h
// RULE_09: timer2 control clears on resets, bit7 zero
// RULE_10: status upper three clear, cause bits set
// RULE_11: irq control clears except bit 0
// RULE_12: pc high latch clears on resets
// RULE_13: code protect blocks readout, 13-5 read 1
`timescale 1ns/1ps
module config_word_and_reset_init
(
    input wire logic i_clk,
    input wire logic i_rst,
    // Programmer side
    input wire logic i_prog_mode,
    input wire logic [13:0] i_prog_addr,
    input wire logic i_prog_write,
    input wire logic [13:0] i_prog_wdata,
    input wire logic i_prog_read,
    output logic [13:0] o_prog_rdata,
    output logic o_prog_rvalid,
    output logic o_readout_blocked,
    // Reset and wake-up events, one-cycle pulses
    input wire logic i_power_on_reset,
    input wire logic i_brownout_reset,
    input wire logic i_master_clear_input,
    input wire logic i_watchdog_reset,
    input wire logic i_wakeup,
    input wire logic [7:0] i_wake_irq_flags,
    input wire logic [7:0] i_wake_periph_a_flags,
    input wire logic [7:0] i_wake_periph_b_flags,
    input wire logic [12:0] i_wake_pc,
    input wire logic [1:0] i_cause_bits,
    // Core software writes and watchdog RC tick
    input wire logic i_sw_watchdog_off,
    input wire logic i_core_write,
    input wire logic [7:0] i_core_wdata,
    input wire logic [2:0] i_core_sel,
    input wire logic i_watchdog_rc_tick,
    // Decoded configuration
    output logic [1:0] o_osc_select_field,
    output logic o_watchdog_enable_cfg,
    output logic o_powerup_delay_enable,
    output logic o_code_protect_bit,
    output logic o_watchdog_run,
    output logic o_watchdog_rc_tick,
    // Register states
    output logic [7:0] o_timer2_control_reg,
    output logic [7:0] o_status_reg,
    output logic [7:0] o_irq_control_reg,
    output logic [7:0] o_periph_flag_reg_a,
    output logic [7:0] o_periph_flag_reg_b,
    output logic [4:0] o_pc_high_latch,
    output logic [12:0] o_pc_load,
    output logic o_pc_load_valid,
    output cfg_init_pkg::reset_cause_t o_last_cause
);
    logic [13:0] cfg_word_reg;
    logic [13:0] cfg_readback;
    logic hard_reset;
    logic soft_reset;
    logic in_test_region;
    logic core_wr_t2;
    logic core_wr_st;
    logic core_wr_ic;
    logic core_wr_pa;
    logic core_wr_pb;
    logic core_wr_ph;

    // ----------------------------------------
    // Address and event decode
    // ----------------------------------------
    // RULE_03: region gated by programming mode
    assign in_test_region = i_prog_mode && (i_prog_addr >= cfg_init_pkg::TEST_REGION_LO)
        && (i_prog_addr <= cfg_init_pkg::TEST_REGION_HI);
    assign hard_reset = i_power_on_reset | i_brownout_reset;
    assign soft_reset = i_master_clear_input | i_watchdog_reset;
    assign core_wr_t2 = i_core_write && (i_core_sel == 3'h0);
    assign core_wr_st = i_core_write && (i_core_sel == 3'h1);
    assign core_wr_ic = i_core_write && (i_core_sel == 3'h2);
    assign core_wr_pa = i_core_write && (i_core_sel == 3'h3);
    assign core_wr_pb = i_core_write && (i_core_sel == 3'h4);
    assign core_wr_ph = i_core_write && (i_core_sel == 3'h5);

    // ----------------------------------------
    // Configuration word storage
    // ----------------------------------------
    // RULE_01: erased word is all ones
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            cfg_word_reg <= cfg_init_pkg::CFG_ERASED;
        // RULE_02: word written only at 2007h
        else if (in_test_region && i_prog_write && (i_prog_addr == cfg_init_pkg::CFG_WORD_ADDR))
            cfg_word_reg <= i_prog_wdata;
    end

    cfg_word_decode u_decode
    (
        .i_cfg_word(cfg_word_reg),
        .o_osc_select_field(o_osc_select_field),
        .o_watchdog_enable_cfg(o_watchdog_enable_cfg),
        .o_powerup_delay_enable(o_powerup_delay_enable),
        .o_code_protect_bit(o_code_protect_bit),
        .o_cfg_readback(cfg_readback)
    );

    // Programmer readback
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_prog_rdata <= 14'h0000;
            o_prog_rvalid <= 1'b0;
            o_readout_blocked <= 1'b0;
        end
        else
        begin
            o_prog_rvalid <= i_prog_read && i_prog_mode;
            o_readout_blocked <= 1'b0;
            if (i_prog_read && in_test_region && (i_prog_addr == cfg_init_pkg::CFG_WORD_ADDR))
                o_prog_rdata <= cfg_readback;
            // RULE_13: protected program memory reads zero
            else if (i_prog_read && i_prog_mode && !in_test_region && !o_code_protect_bit)
            begin
                o_prog_rdata <= 14'h0000;
                o_readout_blocked <= 1'b1;
            end
            else if (i_prog_read)
                o_prog_rdata <= 14'h0000;
        end
    end

    // ----------------------------------------
    // Watchdog enable
    // ----------------------------------------
    // RULE_06: software off ignored when enabled
    assign o_watchdog_run = o_watchdog_enable_cfg | (1'b0 & i_sw_watchdog_off);
    assign o_watchdog_rc_tick = o_watchdog_run & i_watchdog_rc_tick;

    // ----------------------------------------
    // Timer2 control and pc high latch
    // ----------------------------------------
    // RULE_09: cleared on every reset, kept on wake
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_timer2_control_reg <= cfg_init_pkg::TIMER2_CTRL_RESET;
        else if (hard_reset || soft_reset)
            o_timer2_control_reg <= cfg_init_pkg::TIMER2_CTRL_RESET;
        else if (core_wr_t2)
            o_timer2_control_reg <= i_core_wdata & cfg_init_pkg::TIMER2_CTRL_MASK;
    end

    // RULE_12: latch cleared on every reset
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_pc_high_latch <= cfg_init_pkg::PC_HIGH_RESET;
        else if (hard_reset || soft_reset)
            o_pc_high_latch <= cfg_init_pkg::PC_HIGH_RESET;
        else if (core_wr_ph)
            o_pc_high_latch <= i_core_wdata[4:0];
    end

    // ----------------------------------------
    // Status register
    // ----------------------------------------
    // RULE_10: upper clear, cause bits, low kept
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_status_reg <= cfg_init_pkg::STATUS_POR_RESET;
        else if (hard_reset)
            o_status_reg <= {cfg_init_pkg::STATUS_POR_RESET[7:3], o_status_reg[2:0]};
        else if (soft_reset)
            o_status_reg <= {3'h0, i_cause_bits,
                o_status_reg[2:0] & cfg_init_pkg::STATUS_KEEP_LOW_MASK[2:0]};
        else if (i_wakeup)
            o_status_reg <= {o_status_reg[7:5], i_cause_bits, o_status_reg[2:0]};
        else if (core_wr_st)
            o_status_reg <= i_core_wdata;
    end

    // ----------------------------------------
    // Interrupt control and flag registers
    // ----------------------------------------
    // RULE_11: clear all but bit 0
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_irq_control_reg <= 8'h00;
        else if (hard_reset || soft_reset)
            o_irq_control_reg <= o_irq_control_reg & cfg_init_pkg::IRQ_CTRL_KEEP_MASK;
        // RULE_07: wake source flags set
        else if (i_wakeup)
            o_irq_control_reg <= o_irq_control_reg | i_wake_irq_flags;
        else if (core_wr_ic)
            o_irq_control_reg <= i_core_wdata;
    end

    // RULE_07: peripheral wake flags, set beats write
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_periph_flag_reg_a <= 8'h00;
            o_periph_flag_reg_b <= 8'h00;
        end
        else if (hard_reset || soft_reset)
        begin
            o_periph_flag_reg_a <= 8'h00;
            o_periph_flag_reg_b <= 8'h00;
        end
        else
        begin
            if (core_wr_pa)
                o_periph_flag_reg_a <= i_core_wdata | (i_wakeup ? i_wake_periph_a_flags : 8'h00);
            else if (i_wakeup)
                o_periph_flag_reg_a <= o_periph_flag_reg_a | i_wake_periph_a_flags;
            if (core_wr_pb)
                o_periph_flag_reg_b <= i_core_wdata | (i_wakeup ? i_wake_periph_b_flags : 8'h00);
            else if (i_wakeup)
                o_periph_flag_reg_b <= o_periph_flag_reg_b | i_wake_periph_b_flags;
        end
    end

    // ----------------------------------------
    // Program counter load and cause record
    // ----------------------------------------
    // RULE_08: 0004h vector when enabled and flagged, else PC+1
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pc_load <= 13'h0000;
            o_pc_load_valid <= 1'b0;
        end
        else if (hard_reset || soft_reset)
        begin
            o_pc_load <= 13'h0000;
            o_pc_load_valid <= 1'b1;
        end
        else if (i_wakeup)
        begin
            o_pc_load <= (o_irq_control_reg[cfg_init_pkg::IRQ_GIE_POS] && (|i_wake_irq_flags))
                ? cfg_init_pkg::IRQ_VECTOR : i_wake_pc + 13'h0001;
            o_pc_load_valid <= 1'b1;
        end
        else
            o_pc_load_valid <= 1'b0;
    end

    // Most recent reset or wake cause
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_last_cause <= cfg_init_pkg::CAUSE_NONE;
        else if (i_power_on_reset)
            o_last_cause <= cfg_init_pkg::CAUSE_POWER_ON;
        else if (i_brownout_reset)
            o_last_cause <= cfg_init_pkg::CAUSE_BROWNOUT;
        else if (i_master_clear_input)
            o_last_cause <= cfg_init_pkg::CAUSE_MASTER_CLEAR;
        else if (i_watchdog_reset)
            o_last_cause <= cfg_init_pkg::CAUSE_WATCHDOG;
        else if (i_wakeup)
            o_last_cause <= cfg_init_pkg::CAUSE_WAKEUP;
    end
endmodule

// ---- testbench/cfg_init_sva.sv ----
// Concurrent checks on the configuration and reset initialiser ports
`timescale 1ns/1ps
module cfg_init_chk
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_prog_mode,
    input wire logic [13:0] i_prog_addr,
    input wire logic i_prog_read,
    input wire logic o_readout_blocked,
    input wire logic o_code_protect_bit,
    input wire logic i_power_on_reset,
    input wire logic i_brownout_reset,
    input wire logic i_master_clear_input,
    input wire logic i_watchdog_reset,
    input wire logic i_wakeup,
    input wire logic [7:0] i_wake_irq_flags,
    input wire logic [1:0] i_cause_bits,
    input wire logic i_sw_watchdog_off,
    input wire logic o_watchdog_enable_cfg,
    input wire logic o_watchdog_run,
    input wire logic [7:0] o_timer2_control_reg,
    input wire logic [7:0] o_status_reg,
    input wire logic [7:0] o_irq_control_reg,
    input wire logic [4:0] o_pc_high_latch,
    input wire logic [12:0] o_pc_load,
    input wire logic o_pc_load_valid
);
    // ------------------------------------------------------------
    // Reset event decode and properties
    // ------------------------------------------------------------
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic hard_rst;
    logic soft_rst;
    // Power events outrank clear and watchdog events
    assign hard_rst = i_power_on_reset | i_brownout_reset;
    assign soft_rst = (i_master_clear_input | i_watchdog_reset) & ~hard_rst;
    sequence s_gie_wake;
        i_wakeup && !hard_rst && !soft_rst && o_irq_control_reg[7] && (i_wake_irq_flags != 8'h00);
    endsequence
    sequence s_vector_load;
        o_pc_load_valid && (o_pc_load == 13'h0004);
    endsequence
    a_t2_top_zero: assert property (o_timer2_control_reg[7] == 1'b0)
        else $error("timer2 control bit 7 set");
    a_t2_reset_clear: assert property (hard_rst | soft_rst |=> o_timer2_control_reg == 8'h00)
        else $error("timer2 control not cleared");
    a_pch_reset_clear: assert property (hard_rst | soft_rst |=> o_pc_high_latch == 5'h00)
        else $error("pc high latch not cleared");
    a_status_soft_reset: assert property (soft_rst |=> o_status_reg[7:5] == 3'b000 &&
        o_status_reg[4:3] == $past(i_cause_bits) && o_status_reg[2:0] == $past(o_status_reg[2:0]))
        else $error("status wrong after clear event");
    a_irq_soft_reset: assert property (soft_rst |=> o_irq_control_reg[7:1] == 7'h00 &&
        o_irq_control_reg[0] == $past(o_irq_control_reg[0]))
        else $error("irq control wrong after clear event");
    a_wdt_not_stopped: assert property (o_watchdog_enable_cfg && i_sw_watchdog_off |-> o_watchdog_run)
        else $error("watchdog stopped by software");
    a_wake_vector_load: assert property (s_gie_wake |=> s_vector_load)
        else $error("wake did not vector");
    a_read_blocked: assert property (i_prog_read && i_prog_mode && i_prog_addr < 14'h2000 &&
        !o_code_protect_bit |=> o_readout_blocked)
        else $error("protected read not refused");
endmodule
bind config_word_and_reset_init cfg_init_chk u_chk (.i_clk, .i_rst, .i_prog_mode, .i_prog_addr,
    .i_prog_read, .o_readout_blocked, .o_code_protect_bit, .i_power_on_reset, .i_brownout_reset,
    .i_master_clear_input, .i_watchdog_reset, .i_wakeup, .i_wake_irq_flags, .i_cause_bits,
    .i_sw_watchdog_off, .o_watchdog_enable_cfg, .o_watchdog_run, .o_timer2_control_reg,
    .o_status_reg, .o_irq_control_reg, .o_pc_high_latch, .o_pc_load, .o_pc_load_valid);

// ---- testbench/prog_model.sv ----
// Device programmer model driving the configuration access port
`timescale 1ns/1ps
module prog_model
(
    input wire logic i_clk,
    output logic o_mode,
    output logic [13:0] o_addr,
    output logic o_write,
    output logic [13:0] o_wdata,
    output logic o_read
);
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // Idle bus, called once at time zero by the bench
    task automatic init;
        {o_mode, o_write, o_read, o_addr, o_wdata} = 31'h0;
    endtask
    task automatic mode(input logic m);
        @(negedge i_clk);
        o_mode = m;
    endtask
    // One-cycle write or read, bus inverted once released
    task automatic acc(input logic w, input logic [13:0] a, input logic [13:0] d);
        @(negedge i_clk);
        {o_addr, o_wdata, o_write, o_read} = {a, d, w, ~w};
        @(negedge i_clk);
        {o_addr, o_wdata, o_write, o_read} = {~a, ~d, 2'b00};
    endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the configuration and reset initialiser
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb;
    // ------------------------------------------------------------
    // Signals, instances and scenarios
    // ------------------------------------------------------------
    logic i_clk = 1'b0, i_rst = 1'b1, i_prog_mode, i_prog_write, i_prog_read;
    logic o_prog_rvalid, o_powerup_delay_enable;
    cfg_init_pkg::reset_cause_t o_last_cause;
    logic [13:0] i_prog_addr, i_prog_wdata, o_prog_rdata;
    logic i_sw_watchdog_off = 1'b1, i_core_write = 1'b0, i_watchdog_rc_tick = 1'b1;
    logic [4:0] evt = 5'h00, o_pc_high_latch;
    logic [7:0] i_wake_irq_flags = 8'h00, i_wake_periph_a_flags = 8'h00, i_core_wdata = 8'h00;
    logic [7:0] i_wake_periph_b_flags = 8'h00, o_timer2_control_reg, o_status_reg;
    logic [7:0] o_irq_control_reg, o_periph_flag_reg_a, o_periph_flag_reg_b;
    logic [12:0] i_wake_pc = 13'h0100, o_pc_load, pc_low_byte;
    logic [1:0] i_cause_bits = 2'b00, o_osc_select_field;
    logic [2:0] i_core_sel = 3'h0;
    logic o_readout_blocked, o_watchdog_enable_cfg, o_code_protect_bit, o_watchdog_run;
    logic o_watchdog_rc_tick, o_pc_load_valid;
    int checks = 0, miscompares = 0;
    int pcv_n = 0, blk_n = 0, rv_n = 0;
    always #2.5 i_clk = ~i_clk;
    prog_model prog (.i_clk, .o_mode(i_prog_mode), .o_addr(i_prog_addr), .o_write(i_prog_write),
        .o_wdata(i_prog_wdata), .o_read(i_prog_read));
    config_word_and_reset_init DUT (.i_clk, .i_rst, .i_prog_mode, .i_prog_addr, .i_prog_write,
        .i_prog_wdata, .i_prog_read, .o_prog_rdata, .o_prog_rvalid, .o_readout_blocked,
        .i_power_on_reset(evt[0]), .i_brownout_reset(evt[1]), .i_master_clear_input(evt[2]),
        .i_watchdog_reset(evt[3]), .i_wakeup(evt[4]), .i_wake_irq_flags, .i_wake_periph_a_flags,
        .i_wake_periph_b_flags, .i_wake_pc, .i_cause_bits, .i_sw_watchdog_off, .i_core_write,
        .i_core_wdata, .i_core_sel, .i_watchdog_rc_tick, .o_osc_select_field, .o_watchdog_run,
        .o_watchdog_enable_cfg, .o_powerup_delay_enable, .o_code_protect_bit, .o_pc_load,
        .o_watchdog_rc_tick, .o_timer2_control_reg, .o_status_reg, .o_irq_control_reg,
        .o_periph_flag_reg_a, .o_periph_flag_reg_b, .o_pc_high_latch, .o_pc_load_valid,
        .o_last_cause);
    // Count one-cycle answer pulses, sampled mid-cycle
    always @(negedge i_clk)
    begin
        if (o_pc_load_valid)
        begin
            pcv_n <= pcv_n + 1;
            pc_low_byte <= o_pc_load;
        end
        if (o_readout_blocked)
            blk_n <= blk_n + 1;
        if (o_prog_rvalid)
            rv_n <= rv_n + 1;
    end
    task automatic ev(input logic [4:0] e);
        @(negedge i_clk);
        evt = e;
        @(negedge i_clk);
        evt = 5'h00;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic cw(input logic [2:0] s, input logic [7:0] d);
        @(negedge i_clk);
        {i_core_sel, i_core_wdata, i_core_write} = {s, d, 1'b1};
        @(negedge i_clk);
        i_core_write = 1'b0;
    endtask
    task automatic rd(input logic [13:0] a, input logic [13:0] e, input int v);
        int r0;
        r0 = rv_n;
        prog.acc(1'b0, a, 14'h0000);
        @(negedge i_clk);
        `CHK("rdata", e, o_prog_rdata)
        `CHK("rvalid", v, rv_n - r0)
    endtask
    task automatic t_cfg;
        logic [13:0] w;
        int nb;
        prog.acc(1'b1, 14'h2007, 14'h0000);
        rd(14'h2007, 14'h0000, 0);
        prog.mode(1'b1);
        prog.acc(1'b1, 14'h2006, 14'h0000);
        rd(14'h2007, 14'h3FFF, 1);
        for (int k = 0; k < 4; k++)
        begin
            w = 14'h0010 | 14'(k) | (14'(k & 1) << 2);
            prog.acc(1'b1, 14'h2007, w);
            `CHK("osc", 2'(k), o_osc_select_field)
            `CHK("run", 1'(k & 1), o_watchdog_run)
            `CHK("tick", 1'(k & 1), o_watchdog_rc_tick)
            `CHK("cp", 1'b1, o_code_protect_bit)
            `CHK("pwrt", 1'b0, o_powerup_delay_enable)
            rd(14'h2007, w | 14'h3FE0, 1);
        end
        prog.acc(1'b1, 14'h2007, 14'h0007);
        `CHK("cp", 1'b0, o_code_protect_bit)
        nb = blk_n;
        rd(14'h0010, 14'h0000, 1);
        `CHK("blocked", 1, blk_n - nb)
    endtask
    task automatic t_rst;
        cw(3'h0, 8'hFF);
        cw(3'h1, 8'hFF);
        cw(3'h2, 8'hFF);
        cw(3'h5, 8'h1F);
        `CHK("t2w", 8'h7F, o_timer2_control_reg)
        i_cause_bits = 2'b10;
        ev(5'h04);
        `CHK("status", 8'h17, o_status_reg)
        `CHK("cause", cfg_init_pkg::CAUSE_MASTER_CLEAR, o_last_cause)
        `CHK("irq", 8'h01, o_irq_control_reg)
        `CHK("t2", 8'h00, o_timer2_control_reg)
        `CHK("pch", 5'h00, o_pc_high_latch)
        cw(3'h2, 8'hFE);
        i_cause_bits = 2'b01;
        ev(5'h08);
        `CHK("status", 8'h0F, o_status_reg)
        `CHK("irq", 8'h00, o_irq_control_reg)
        `CHK("cause", cfg_init_pkg::CAUSE_WATCHDOG, o_last_cause)
        ev(5'h02);
        `CHK("status", 8'h1F, o_status_reg)
        `CHK("cause", cfg_init_pkg::CAUSE_BROWNOUT, o_last_cause)
    endtask
    task automatic t_wake(input logic [7:0] irq, input logic [12:0] pc);
        int np;
        cw(3'h2, irq);
        cw(3'h1, 8'hE5);
        cw(3'h5, 8'h05);
        cw(3'h0, 8'h33);
        i_wake_periph_a_flags = 8'h04;
        i_wake_periph_b_flags = 8'h08;
        np = pcv_n;
        ev(5'h10);
        `CHK("pcv", 1, pcv_n - np)
        `CHK("status", ({3'b111, i_cause_bits, 3'b101}), o_status_reg)
        `CHK("cause", cfg_init_pkg::CAUSE_WAKEUP, o_last_cause)
        `CHK("pcl", pc, pc_low_byte)
        `CHK("irq", irq | i_wake_irq_flags, o_irq_control_reg)
        `CHK("fa", 8'h04, o_periph_flag_reg_a)
        `CHK("fb", 8'h08, o_periph_flag_reg_b)
        `CHK("pch", 5'h05, o_pc_high_latch)
        `CHK("t2", 8'h33, o_timer2_control_reg)
    endtask
    task automatic test_done;
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        prog.init;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        `CHK("osc", 2'b11, o_osc_select_field)
        `CHK("pwrt", 1'b1, o_powerup_delay_enable)
        `CHK("status", 8'h18, o_status_reg)
        `CHK("pch", 5'h00, o_pc_high_latch)
        t_cfg;
        t_rst;
        i_wake_irq_flags = 8'h02;
        t_wake(8'h80, 13'h0004);
        i_wake_irq_flags = 8'h00;
        t_wake(8'h00, 13'h0101);
        test_done;
    end
endmodule
